// File: rtl/motor_status_cfg.svh
`ifndef MOTOR_STATUS_CFG_SVH
`define MOTOR_STATUS_CFG_SVH

// Word indices; the byte address on the bus is four times the index.
`define IDX_W 14
`define IDX_CONTROL_PHASE 14'h0210
`define IDX_TACH_SPEED 14'h0216
`define IDX_SUPPLY_CURRENT 14'h0410
`define IDX_INITIAL_ANGLE 14'h06fc
`define IDX_BEMF_D 14'h0742
`define IDX_BEMF_Q 14'h0744
`define IDX_ROTOR_SPEED 14'h0752
`define IDX_ROTOR_ANGLE 14'h0756
`define IDX_EVT_STATUS 14'h0800
`define IDX_EVT_ENABLE 14'h0801
`define IDX_EVT_CLEAR 14'h0802
`define IDX_SNAP_CTRL 14'h0803

// Reset values.
`define WORD_RESET 32'h00000000
`define PHASE_RESET 16'h0000
`define EVT_RESET 5'h00
`define CTRL_RESET 1'b0

// Field positions.
`define PHASE_W 16
`define EVT_COUNT 5
`define EVT_PHASE_CHANGE 0
`define EVT_FAULT 1
`define EVT_MEAS_FAULT 2
`define EVT_SAMPLE 3
`define EVT_SAMPLE_MISSED 4
`define CTRL_FREEZE_BIT 0

// Control-phase codes; all but idle raise their own events.
`define PHASE_IDLE 16'h0000
`define PHASE_FAULT 16'h000e
`define PHASE_MEAS_FAULT 16'h0018

// Fixed-point fraction width of speed and current words.
`define FRAC_BITS 27

`endif

// File: rtl/motor_status_pkg.sv
`include "motor_status_cfg.svh"

package motor_status_pkg;

  // Bus answer state.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_state_t;

  // Sticky event flags, their enables and the interrupt line.
  typedef struct packed {
    logic [`EVT_COUNT-1:0] status;
    logic [`EVT_COUNT-1:0] enable;
    logic irq;
  } event_state_t;

  // Snapshot of the algorithm variables plus control.
  typedef struct packed {
    logic [`PHASE_W-1:0] phase;
    logic [31:0] tach;
    logic [31:0] supply;
    logic [31:0] angle;
    logic [31:0] bemf_d;
    logic [31:0] bemf_q;
    logic [31:0] rspeed;
    logic [31:0] rangle;
    logic freeze;
  } snap_state_t;

endpackage : motor_status_pkg

// File: rtl/apb_word_port.sv
`timescale 1ns/10ps
`default_nettype none

`include "motor_status_cfg.svh"

module apb_word_port (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [15:0] paddr, // APB byte address.
  input wire logic [31:0] rd_data, // Read word for the current index.
  input wire logic rd_hit, // Current index is mapped.
  output logic [`IDX_W-1:0] index, // Word index of the access.
  output logic wr_en, // Write takes effect this edge.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr // APB error.
);

  motor_status_pkg::apb_state_t s_q;
  motor_status_pkg::apb_state_t s_d;
  logic hit;

  // Unaligned addresses are treated as unmapped.
  assign index = paddr[15:2];
  assign hit = rd_hit & (paddr[1:0] == 2'h0);
  // A write lands only on the edge where the master sees pready.
  assign wr_en = psel & penable & pwrite & s_q.pready & hit;

  // One wait state: ready is raised in the second access cycle.
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~hit;
      s_d.prdata = (!pwrite && hit) ? rd_data : 32'h00000000;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{prdata: `WORD_RESET, pready: 1'b0, pslverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule : apb_word_port

`default_nettype wire

// File: rtl/event_flags.sv
`timescale 1ns/10ps
`default_nettype none

`include "motor_status_cfg.svh"

module event_flags (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [`EVT_COUNT-1:0] set, // Event pulses.
  input wire logic clr_wr, // Write to the clear register.
  input wire logic en_wr, // Write to the enable register.
  input wire logic [`EVT_COUNT-1:0] wdata, // Write data bits.
  output logic [`EVT_COUNT-1:0] status, // Sticky flags.
  output logic [`EVT_COUNT-1:0] enable, // Interrupt enables.
  output logic irq // Level interrupt.
);

  motor_status_pkg::event_state_t s_q;
  motor_status_pkg::event_state_t s_d;
  logic [`EVT_COUNT-1:0] clr;

  assign clr = clr_wr ? wdata : '0;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    s_d = s_q;
    s_d.status = (s_q.status & ~clr) | set;
    if (en_wr) begin
      s_d.enable = wdata;
    end
    s_d.irq = |(s_d.status & s_d.enable);
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{status: `EVT_RESET, enable: `EVT_RESET, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign enable = s_q.enable;
  assign irq = s_q.irq;

endmodule : event_flags

`default_nettype wire

// File: rtl/motor_algorithm_status_regs.sv
// How it works
// - Phase code in low 16 bits
// - Tach speed as 32-bit unsigned fraction
// - Supply current as 32-bit scaled word
// - Initial angle word, zero after reset
// - Back-EMF words at their offsets, zero
// - Speed and angle estimates, zero after reset
`timescale 1ns/10ps
`default_nettype none

`include "motor_status_cfg.svh"

module motor_algorithm_status_regs (
  input wire logic clock, // System clock, 20 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [15:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic sample_strobe, // New algorithm values are valid.
  input wire logic [15:0] phase_code_in, // Present control phase.
  input wire logic [31:0] tach_speed_in, // Speed from tach output.
  input wire logic [31:0] supply_current_in, // Calculated supply current.
  input wire logic [31:0] initial_angle_in, // Initial-position angle.
  input wire logic [31:0] bemf_d_in, // Back-EMF, direct axis.
  input wire logic [31:0] bemf_q_in, // Back-EMF, quadrature axis.
  input wire logic [31:0] rotor_speed_in, // Estimated rotor speed.
  input wire logic [31:0] rotor_angle_in, // Estimated rotor position.
  output logic irq // Level interrupt, high while an enabled flag is set.
);

  motor_status_pkg::snap_state_t s_q;
  motor_status_pkg::snap_state_t s_d;

  logic [`IDX_W-1:0] index;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_hit;
  logic capture;
  logic phase_change;
  logic [`EVT_COUNT-1:0] evt_set;
  logic [`EVT_COUNT-1:0] evt_status;
  logic [`EVT_COUNT-1:0] evt_enable;
  logic ctrl_wr;

  // Bus front end: decode, one wait state and the error answer.
  apb_word_port bus (
    .clock(clock),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .index(index),
    .wr_en(wr_en),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // A freeze holds every captured word still so software can read a coherent set.
  // Strobes that arrive while frozen are dropped and flagged instead.
  assign capture = sample_strobe & ~s_q.freeze;
  assign phase_change = capture & (phase_code_in != s_q.phase);

  // Event pulses, one per flag position.
  always_comb begin
    evt_set = '0;
    evt_set[`EVT_PHASE_CHANGE] = phase_change;
    evt_set[`EVT_FAULT] = phase_change & (phase_code_in == `PHASE_FAULT);
    evt_set[`EVT_MEAS_FAULT] = phase_change & (phase_code_in == `PHASE_MEAS_FAULT);
    evt_set[`EVT_SAMPLE] = capture;
    evt_set[`EVT_SAMPLE_MISSED] = sample_strobe & s_q.freeze;
  end

  // Sticky status, enable and interrupt.
  event_flags events (
    .clock(clock),
    .rst(rst),
    .set(evt_set),
    .clr_wr(wr_en && (index == `IDX_EVT_CLEAR)),
    .en_wr(wr_en && (index == `IDX_EVT_ENABLE)),
    .wdata(pwdata[`EVT_COUNT-1:0]),
    .status(evt_status),
    .enable(evt_enable),
    .irq(irq)
  );

  assign ctrl_wr = wr_en && (index == `IDX_SNAP_CTRL);

  // Next snapshot. Data words take no bus writes at all.
  always_comb begin
    s_d = s_q;
    if (capture) begin
      s_d.phase = phase_code_in;
      s_d.tach = tach_speed_in;
      s_d.supply = supply_current_in;
      s_d.angle = initial_angle_in;
      s_d.bemf_d = bemf_d_in;
      s_d.bemf_q = bemf_q_in;
      s_d.rspeed = rotor_speed_in;
      s_d.rangle = rotor_angle_in;
    end
    if (ctrl_wr) begin
      s_d.freeze = pwdata[`CTRL_FREEZE_BIT];
    end
  end

  // Every word clears to zero on reset, freeze included.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.phase <= `PHASE_RESET;
      s_q.tach <= `WORD_RESET;
      s_q.supply <= `WORD_RESET;
      s_q.angle <= `WORD_RESET;
      s_q.bemf_d <= `WORD_RESET;
      s_q.bemf_q <= `WORD_RESET;
      s_q.rspeed <= `WORD_RESET;
      s_q.rangle <= `WORD_RESET;
      s_q.freeze <= `CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Read mux. Speed and current are passed through unscaled; software
  // divides by 2^FRAC_BITS and applies full-scale speed or 1.25 A.
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    unique case (index)
      `IDX_CONTROL_PHASE: rd_data = {16'h0000, s_q.phase};
      `IDX_TACH_SPEED: rd_data = s_q.tach;
      `IDX_SUPPLY_CURRENT: rd_data = s_q.supply;
      `IDX_INITIAL_ANGLE: rd_data = s_q.angle;
      `IDX_BEMF_D: rd_data = s_q.bemf_d;
      `IDX_BEMF_Q: rd_data = s_q.bemf_q;
      `IDX_ROTOR_SPEED: rd_data = s_q.rspeed;
      `IDX_ROTOR_ANGLE: rd_data = s_q.rangle;
      `IDX_EVT_STATUS: rd_data = {{(32 - `EVT_COUNT){1'b0}}, evt_status};
      `IDX_EVT_ENABLE: rd_data = {{(32 - `EVT_COUNT){1'b0}}, evt_enable};
      `IDX_EVT_CLEAR: rd_data = 32'h00000000;
      `IDX_SNAP_CTRL: rd_data = {31'h00000000, s_q.freeze};
      default: rd_hit = 1'b0;
    endcase
  end

endmodule : motor_algorithm_status_regs

`default_nettype wire

// File: tb/motor_status_chk.sv
`timescale 1ns/10ps
`default_nettype none
module motor_status_chk (
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [15:0] paddr, // Address.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic irq // Interrupt.
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // An access phase still waiting for its answer.
  logic acc;
  assign acc = psel && penable && !pready;
  property p_wait; acc |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_err; acc && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unaligned taken");
  property p_errq; pslverr |-> pready; endproperty
  a_errq: assert property (p_errq) else $error("lone error");
  property p_phase; pready && !pwrite && paddr == 16'h0840 |-> prdata[31:16] == 16'h0 && !pslverr; endproperty
  a_phase: assert property (p_phase) else $error("phase upper bits");
  property p_wzero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wzero: assert property (p_wzero) else $error("write data back");
  property p_rst; $fell(rst) |-> !pready && !irq && prdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("not quiet after reset");
endmodule : motor_status_chk
bind motor_algorithm_status_regs motor_status_chk u_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .irq);
`default_nettype wire

// File: tb/motor_algorithm_status_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module motor_algorithm_status_regs_tb;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, strobe = 1'b0;
  logic [15:0] paddr = 16'h0, code = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, v [8] = '{default: 32'h0};
  logic pready, pslverr, irq, err;
  int failures = 0, n_tests = 0, cyc = 0, i;
  logic [15:0] adr [8] = '{16'h0840, 16'h0858, 16'h1040, 16'h1bf0, 16'h1d08, 16'h1d10, 16'h1d48, 16'h1d58};
  motor_algorithm_status_regs DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_strobe(strobe), .phase_code_in(code), .tach_speed_in(v[1]),
    .supply_current_in(v[2]), .initial_angle_in(v[3]), .bemf_d_in(v[4]), .bemf_q_in(v[5]),
    .rotor_speed_in(v[6]), .rotor_angle_in(v[7]), .irq(irq));
  // Free-running clock, 50 ns period.
  initial begin
    forever #25 clock = ~clock;
  end
  // A hung handshake ends the run here rather than never.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // One transfer; the request holds until ready is sampled high.
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No wait limit here; only the bench timeout ends a hung access.
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer
  task rchk(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
    check({31'h0, err}, 32'h0);
  endtask : rchk
  task strb();
    strobe <= 1'b1;
    @(posedge clock);
    strobe <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : strb
  task complete_run();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Main sequence.
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 8; i++) rchk(adr[i], 32'h0);
    for (i = 1; i < 8; i++) v[i] <= 32'h0800_0000 + i;
    for (i = 0; i < 25; i++) begin
      code <= i[15:0];
      strb();
      rchk(16'h0840, {16'h0, i[15:0]});
    end
    for (i = 1; i < 8; i++) rchk(adr[i], 32'h0800_0000 + i);
    // Writes must leave every word as it was.
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, adr[i], 32'hffff_ffff);
      check({31'h0, err}, 32'h0);
      rchk(adr[i], i == 0 ? 32'h18 : 32'h0800_0000 + i);
    end
    xfer(1'b0, 16'h0842, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    xfer(1'b0, 16'h0004, 32'h0);
    check({31'h0, err}, 32'h1);
    rchk(16'h2000, 32'h0f);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, 16'h2004, 32'h2);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, 16'h2008, 32'h0f);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    rchk(16'h2000, 32'h0);
    // Frozen: a new sample is refused and only flagged as missed.
    xfer(1'b1, 16'h2004, 32'h10);
    xfer(1'b1, 16'h200c, 32'h1);
    code <= 16'h0003;
    strb();
    check({31'h0, irq}, 32'h1);
    rchk(16'h0840, 32'h18);
    rchk(16'h2000, 32'h10);
    rchk(16'h2004, 32'h10);
    rchk(16'h200c, 32'h1);
    rchk(16'h2008, 32'h0);
    // A second reset must clear captured words, flags and the freeze.
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    for (i = 0; i < 8; i++) rchk(adr[i], 32'h0);
    rchk(16'h2000, 32'h0);
    rchk(16'h200c, 32'h0);
    complete_run();
  end
endmodule : motor_algorithm_status_regs_tb
`default_nettype wire
